// file: rtl/serial_slave_defs.svh
`ifndef SERIAL_SLAVE_DEFS_SVH
`define SERIAL_SLAVE_DEFS_SVH
// register byte offsets
`define OFS_TX_MAX_COUNT   12'h548
`define OFS_FRAME_FORMAT   12'h554
`define OFS_IGNORED_FILL   12'h55C
`define OFS_OVERREAD_FILL  12'h5C0
`define OFS_SLAVE_CTRL     12'h5C4
`define OFS_SLAVE_STATUS   12'h5C8
// reset values
`define RST_FORMAT         3'h0
`define RST_CHAR           8'h00
`define RST_MAX_COUNT      14'h0000
`define RST_IGNORE         1'h0
// field positions
`define FMT_MSB            2
`define CHAR_MSB           7
`define CNT_MSB            13
`define STAT_OVR_BIT       16
`define STAT_ACT_BIT       17
`define CTRL_IGN_BIT       0
// bit index of the last bit of a character
`define LAST_BIT           3'h7
`define FIRST_BIT          3'h0
`define CNT_ONE            14'h0001
`define CNT_ZERO           14'h0000
`endif

// file: rtl/serial_slave_pkg.sv
`default_nettype none
package serial_slave_pkg;
  // frame format: bit order, clock phase, clock polarity
  typedef struct packed {
    logic cpol;       // 1: clock active low
    logic cpha;       // 1: sample on trailing edge
    logic low_first;  // 1: low_bit_first
  } frame_fmt_t;

  // avalon-mm request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [31:0] writedata;
  } avs_req_t;

  // received byte handed to the rest of the slave
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_byte_t;
endpackage
`default_nettype wire

// file: rtl/serial_slave_unit.sv
// Notes on behaviour
// R1 - order bit picks high or low bit first
// R2 - phase bit picks sample and shift edges
// R3 - polarity bit sets idle clock level
// R4 - ignored transaction sends the ignored fill char
// R5 - past buffer end send over-read fill char
// R6 - max count bounds bytes taken from buffer
// R7 - fill chars are bytes, same framing as data
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "serial_slave_defs.svh"
`default_nettype none
module serial_slave_unit
  import serial_slave_pkg::*;
(
  input  wire logic       I_REF_CLK,         // 200 MHz system clock
  input  wire logic       I_RSTN,            // async reset, active low
  input  wire avs_req_t   I_AVS_REQ,         // avalon read/write/address/data
  output logic [31:0]     O_AVS_READDATA,    // avalon read data
  output logic            O_AVS_WAITREQUEST, // avalon wait request
  input  wire logic       I_SCK,             // serial clock from master
  input  wire logic       I_CHIP_SELECT_N,   // chip select, active low
  input  wire logic       I_MOSI,            // serial data in
  output logic            O_MISO,            // serial data out
  output logic            O_MISO_OE,         // high while driving miso
  input  wire logic [7:0] I_TX_BYTE,         // buffer byte at the tx index
  output logic [13:0]     O_TX_BYTE_IDX,     // index of next buffer byte
  output var rx_byte_t    O_RX_BYTE          // received byte, valid pulse
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  frame_fmt_t  fmt_q;
  logic [7:0]  fill_ign_q;
  logic [7:0]  fill_ovr_q;
  logic [13:0] max_q;
  logic        ign_ctrl_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        req;

  // serial side state
  logic [2:0]  sck_q;
  logic [2:0]  cs_n_q;
  logic [1:0]  mosi_q;
  logic [7:0]  sh_q;
  logic [2:0]  oidx_q;
  logic        first_q;
  logic [7:0]  rx_q;
  logic [2:0]  ridx_q;
  logic [13:0] cnt_q;
  logic [13:0] amount_q;
  logic        ign_q;
  logic        ovr_q;
  logic        miso_q;
  rx_byte_t    rxo_q;

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer
  assign req               = I_AVS_REQ.read | I_AVS_REQ.write;
  assign O_AVS_WAITREQUEST = req & ~ack_q;
  assign O_AVS_READDATA    = rdata_q;

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // register writes take effect on the accepting edge
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      fmt_q      <= `RST_FORMAT;
      fill_ign_q <= `RST_CHAR;
      fill_ovr_q <= `RST_CHAR;
      max_q      <= `RST_MAX_COUNT;
      ign_ctrl_q <= `RST_IGNORE;
    end else if (I_AVS_REQ.write && ack_q) begin
      if (I_AVS_REQ.address == `OFS_FRAME_FORMAT) begin
        fmt_q <= I_AVS_REQ.writedata[`FMT_MSB:0];
      end else if (I_AVS_REQ.address == `OFS_IGNORED_FILL) begin
        fill_ign_q <= I_AVS_REQ.writedata[`CHAR_MSB:0]; // R7
      end else if (I_AVS_REQ.address == `OFS_OVERREAD_FILL) begin
        fill_ovr_q <= I_AVS_REQ.writedata[`CHAR_MSB:0]; // R7
      end else if (I_AVS_REQ.address == `OFS_TX_MAX_COUNT) begin
        max_q <= I_AVS_REQ.writedata[`CNT_MSB:0];
      end else if (I_AVS_REQ.address == `OFS_SLAVE_CTRL) begin
        ign_ctrl_q <= I_AVS_REQ.writedata[`CTRL_IGN_BIT];
      end
    end
  end

  // read data; unmapped offsets read zero
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= 32'h00000000;
      if (I_AVS_REQ.address == `OFS_FRAME_FORMAT) begin
        rdata_q[`FMT_MSB:0] <= fmt_q;
      end else if (I_AVS_REQ.address == `OFS_IGNORED_FILL) begin
        rdata_q[`CHAR_MSB:0] <= fill_ign_q;
      end else if (I_AVS_REQ.address == `OFS_OVERREAD_FILL) begin
        rdata_q[`CHAR_MSB:0] <= fill_ovr_q;
      end else if (I_AVS_REQ.address == `OFS_TX_MAX_COUNT) begin
        rdata_q[`CNT_MSB:0] <= max_q;
      end else if (I_AVS_REQ.address == `OFS_SLAVE_CTRL) begin
        rdata_q[`CTRL_IGN_BIT] <= ign_ctrl_q;
      end else if (I_AVS_REQ.address == `OFS_SLAVE_STATUS) begin
        rdata_q[`CNT_MSB:0]      <= amount_q;
        rdata_q[`STAT_OVR_BIT]   <= ovr_q;
        rdata_q[`STAT_ACT_BIT]   <= ~cs_n_q[1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; bit 2 is a delayed copy for edge detection
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sck_q  <= 3'h0;
      cs_n_q <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sck_q  <= {sck_q[1:0], I_SCK};
      cs_n_q <= {cs_n_q[1:0], I_CHIP_SELECT_N};
      mosi_q <= {mosi_q[0], I_MOSI};
    end
  end

  logic active, cs_start, cs_end, e_now, e_prev, lead, trail, samp, shft;
  logic load_ign, from_buf, load, adv;
  logic [7:0] next_char;

  assign active   = ~cs_n_q[1];
  assign cs_start = ~cs_n_q[1] & cs_n_q[2];
  assign cs_end   = cs_n_q[1] & ~cs_n_q[2];
  // clock seen in its active sense, so leading is always idle->active
  assign e_now    = sck_q[1] ^ fmt_q.cpol;                    // R3
  assign e_prev   = sck_q[2] ^ fmt_q.cpol;                    // R3
  assign lead     = e_now & ~e_prev;
  assign trail    = ~e_now & e_prev;
  assign samp     = active & (fmt_q.cpha ? trail : lead);     // R2
  assign shft     = active & (fmt_q.cpha ? lead : trail);     // R2

  // character source: ignored fill, buffer, or over-read fill
  assign load_ign  = cs_start ? ign_ctrl_q : ign_q;
  assign from_buf  = ~load_ign & (cnt_q < max_q);             // R6
  assign next_char = load_ign ? fill_ign_q :                  // R4
                     (from_buf ? I_TX_BYTE : fill_ovr_q);     // R5
  assign adv       = shft & ~(fmt_q.cpha & first_q);
  assign load      = cs_start | (adv & (oidx_q == `LAST_BIT));
  assign O_TX_BYTE_IDX = cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // transmit shifter and bit index counter
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sh_q    <= `RST_CHAR;
      oidx_q  <= `FIRST_BIT;
      first_q <= 1'b1;
      ign_q   <= `RST_IGNORE;
    end else begin
      if (cs_start) begin
        ign_q   <= ign_ctrl_q;
        first_q <= 1'b1;
      end else if (shft) begin
        first_q <= 1'b0;
      end
      if (load) begin
        sh_q   <= next_char;                                  // R7
        oidx_q <= `FIRST_BIT;
      end else if (adv) begin
        oidx_q <= oidx_q + 3'h1;
      end
    end
  end

  // buffer byte count; cleared at frame end after its amount is kept
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cnt_q    <= `CNT_ZERO;
      amount_q <= `CNT_ZERO;
      ovr_q    <= 1'b0;
    end else begin
      if (cs_end) begin
        amount_q <= cnt_q;
        cnt_q    <= `CNT_ZERO;
      end else if (load && from_buf) begin
        cnt_q <= cnt_q + `CNT_ONE;                            // R6
      end
      // set wins, so an over-read on the very first char is kept
      if (load && !load_ign && !from_buf) begin
        ovr_q <= 1'b1;                                        // R5
      end else if (cs_start) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // miso bit chosen by bit order
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= fmt_q.low_first ? sh_q[oidx_q] : sh_q[`LAST_BIT - oidx_q]; // R1
    end
  end
  assign O_MISO    = miso_q;
  assign O_MISO_OE = active;

  // receive shifter
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_q   <= `RST_CHAR;
      ridx_q <= `FIRST_BIT;
      rxo_q  <= '0;
    end else begin
      rxo_q.valid <= 1'b0;
      if (cs_start) begin
        ridx_q <= `FIRST_BIT;
      end else if (samp) begin
        rx_q   <= fmt_q.low_first ? {mosi_q[1], rx_q[7:1]} : {rx_q[6:0], mosi_q[1]}; // R1
        ridx_q <= ridx_q + 3'h1;
        if (ridx_q == `LAST_BIT) begin
          rxo_q.valid <= 1'b1;
          rxo_q.data  <= fmt_q.low_first ? {mosi_q[1], rx_q[7:1]} : {rx_q[6:0], mosi_q[1]};
        end
      end
    end
  end
  assign O_RX_BYTE = rxo_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_char_load;
    load && !cs_start;
  endsequence

  a_bit_order: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // R1
    active |=> O_MISO == ($past(fmt_q.low_first) ? $past(sh_q[oidx_q]) : $past(sh_q[`LAST_BIT - oidx_q])))
    else $error("miso bit does not follow bit order");

  a_sample_edge: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // R2
    O_RX_BYTE.valid |-> $past(samp) && $past(e_now) == !$past(fmt_q.cpha))
    else $error("byte completed on wrong clock edge");

  a_clock_sense: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // R3
    lead |-> sck_q[1] == !fmt_q.cpol)
    else $error("leading edge does not leave idle level");

  a_ignored_fill: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // R4
    load && load_ign |=> sh_q == $past(fill_ign_q) && $stable(cnt_q))
    else $error("ignored transaction not sending fill char");

  a_overread_fill: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // R5
    s_char_load ##0 (!load_ign && !from_buf) |=> sh_q == $past(fill_ovr_q) && ovr_q)
    else $error("over-read not sending over-read char");

  a_count_step: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // R6
    load && from_buf && !cs_end |=> cnt_q == $past(cnt_q) + `CNT_ONE && $past(cnt_q) < $past(max_q))
    else $error("buffer count out of step");

  a_char_length: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN) // R7
    adv && oidx_q == `LAST_BIT |-> load ##1 oidx_q == `FIRST_BIT)
    else $error("character not eight bits long");

  a_bus_answer: assert property (@(posedge I_REF_CLK) disable iff (!I_RSTN)
    req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("avalon answer late");

endmodule
`default_nettype wire

// file: tb/spi_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
  output logic      o_sck,  // serial clock, stands still outside frames
  output logic      o_cs_n, // chip select, active low
  output logic      o_mosi, // data to slave
  input  wire logic i_miso  // data from slave
);
  logic [7:0] got[$]; // bytes seen on miso, first bit in bit 7
  // idle lines at time zero
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // one frame of n chars, each char sends mb first bit high, 64 ns period
  task automatic frame(input logic cpol, input logic cpha, input int n, input logic [7:0] mb);
    logic [7:0] sh;
    sh = 8'h00;
    o_sck = cpol;
    #100 o_cs_n = 1'b0;
    #200;
    for (int c = 0; c < n; c++) begin
      for (int b = 7; b >= 0; b--) begin
        if (!cpha) o_mosi = mb[b];
        #32 o_sck = ~cpol;
        if (cpha) o_mosi = mb[b];
        else sh = {sh[6:0], i_miso};
        #32 o_sck = cpol;
        if (cpha) sh = {sh[6:0], i_miso};
      end
      got.push_back(sh);
    end
    #100 o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line shows no stale value
  endtask
endmodule
`default_nettype wire

// file: tb/serial_slave_unit_tb_top.sv
`timescale 1ns/10ps
`include "serial_slave_defs.svh"
`default_nettype none
module serial_slave_unit_tb_top import serial_slave_pkg::*; ;
  logic        clk, rstn, sck, cs_n, mosi, miso, miso_line, oe, wq;
  logic [31:0] rdat, r;
  logic [7:0]  txb;
  logic [13:0] idx;
  avs_req_t    req;
  rx_byte_t    rx;
  logic [7:0]  mem [0:15];
  logic [7:0]  rxq[$];
  int          bad_count, total_checks;
  logic [11:0] ofs [4] = '{`OFS_FRAME_FORMAT, `OFS_IGNORED_FILL, `OFS_OVERREAD_FILL, `OFS_TX_MAX_COUNT};
  logic [31:0] msk [4] = '{32'h7, 32'hFF, 32'hFF, 32'h3FFF};
  serial_slave_unit dut (.I_REF_CLK(clk), .I_RSTN(rstn), .I_AVS_REQ(req), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wq), .I_SCK(sck), .I_CHIP_SELECT_N(cs_n), .I_MOSI(mosi), .O_MISO(miso),
    .O_MISO_OE(oe), .I_TX_BYTE(txb), .O_TX_BYTE_IDX(idx), .O_RX_BYTE(rx));
  // a deselected slave stops driving: the master then sees the inverse of the last bit
  assign miso_line = oe ? miso : ~miso;
  spi_master_model mst (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_line));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // buffer byte follows the index; received bytes are collected
  always @(posedge clk) begin
    txb <= mem[idx[3:0]];
    if (rx.valid === 1'b1) rxq.push_back(rx.data);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t register got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t char got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction
  // one avalon access held until waitrequest is sampled low at a rising edge
  task automatic avs(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h00000000;
    @(posedge clk);
    req <= '{read: ~w, write: w, address: a, writedata: d};
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    if (wq !== 1'b0) begin
      bad_count++;
      $display("ERROR %0t bus wait timeout", $time);
      summarize();
    end else begin
      q = rdat;
      req <= '0;
    end
  endtask
  // program the block, run a frame, compare with the model
  task automatic run(input logic [2:0] fmt, input logic ign, input int mx, input int n);
    logic [7:0] mb, d, o, e;
    logic [31:0] st;
    int amt;
    mb = 8'($urandom);
    d = 8'($urandom);
    o = 8'($urandom);
    for (int i = 0; i < 16; i++) mem[i] = 8'($urandom);
    avs(1'b1, `OFS_FRAME_FORMAT, {29'h0, fmt}, r);
    avs(1'b1, `OFS_IGNORED_FILL, {24'h0, d}, r);
    avs(1'b1, `OFS_OVERREAD_FILL, {24'h0, o}, r);
    avs(1'b1, `OFS_TX_MAX_COUNT, mx, r);
    avs(1'b1, `OFS_SLAVE_CTRL, {31'h0, ign}, r);
    mst.got.delete();
    rxq.delete();
    chk({31'h0, oe}, 32'h0);
    // miso enable must stand while chip select is low
    fork
      mst.frame(fmt[2], fmt[1], n, mb);
      begin
        repeat (40) @(posedge clk);
        chk({31'h0, oe}, 32'h1);
      end
    join
    repeat (10) @(posedge clk);
    chk({31'h0, oe}, 32'h0);
    chk(rxq.size(), n);
    // status: buffer bytes taken and over-read flag of the frame just ended
    amt = ign ? 0 : (mx < n ? mx : n);
    st = 32'h00000000;
    st[`CNT_MSB:0] = amt[13:0];
    st[`STAT_OVR_BIT] = !ign && mx < n;
    avs(1'b0, `OFS_SLAVE_STATUS, 32'h0, r);
    chk(r, st);
    for (int k = 0; k < n; k++) begin
      e = ign ? d : (k < mx ? mem[k] : o);
      chk_byte(mst.got[k], fmt[0] ? rev(e) : e);
      chk_byte(rxq[k], fmt[0] ? rev(mb) : mb);
    end
    $display("test fmt %0d ignore %0d max %0d done", fmt, ign, mx);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #400000;
    bad_count++;
    $display("ERROR %0t run timeout", $time);
    summarize();
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    req = '0;
    bad_count = 0;
    total_checks = 0;
    for (int i = 0; i < 16; i++) mem[i] = 8'h00;
    void'($urandom(76));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    foreach (ofs[i]) begin
      avs(1'b0, ofs[i], 32'h0, r);
      chk(r, 32'h0);
    end
    avs(1'b1, 12'h7F0, 32'hFFFFFFFF, r);
    avs(1'b0, 12'h7F0, 32'h0, r);
    chk(r, 32'h0);
    foreach (ofs[i]) begin
      logic [31:0] v;
      v = $urandom;
      avs(1'b1, ofs[i], v, r);
      avs(1'b0, ofs[i], 32'h0, r);
      chk(r, v & msk[i]);
    end
    $display("test registers done");
    for (int f = 0; f < 8; f++) run(f[2:0], 1'b0, 2, 4);
    run(3'h5, 1'b1, 2, 2);
    run(3'h2, 1'b0, 0, 2);
    summarize();
  end
endmodule
`default_nettype wire
